// *** verilog/analog_reference_supervisor.v ***
/*
  Analog reference supervisor: APB registers, input filtering, signal loss
  with hysteresis and blanking, loop scaling and the sleep/wake function.
  Assumes samples, run state and frequencies come from logic on mclk.
*/
// Implementation choices: the register addresses and register access over APB.
`include "ars_defines.vh"
`default_nettype none
module analog_reference_supervisor #(
  parameter TICK_CYCLES = `ARS_TICK_CYCLES
) (
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [11:0] voltage_sample,
  input wire [11:0] current_sample,
  input wire drive_running,
  input wire [15:0] commanded_freq,
  input wire [15:0] max_frequency_setting,
  output reg voltage_loss,
  output reg current_loss,
  output reg [3:0] loss_action,
  output reg [15:0] scaled_ref,
  output reg [15:0] freq_target,
  output reg sleep_active,
  output reg run_indicator_flash,
  output reg irq
);
  localparam ST_AWAKE = 1'b0;
  localparam ST_ASLEEP = 1'b1;

  // configuration
  reg [3:0] voltage_input_loss_response;
  reg [3:0] current_loop_loss_response;
  reg volt_is_ref;
  reg loop_is_ref;
  reg [11:0] current_loop_low_scale;
  reg [11:0] current_loop_high_scale;
  reg [7:0] loss_blanking_time;
  reg [3:0] input_filter_level;
  reg [1:0] sleep_source_select;
  reg [9:0] sleep_threshold;
  reg [9:0] wake_threshold;
  reg [12:0] sleep_dwell_time;
  reg [12:0] wake_dwell_time;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;

  // state
  reg [31:0] tick_count;
  reg tick;
  reg [7:0] blank_count;
  reg blank_done;
  reg hyst_v;
  reg hyst_i;
  reg state;
  reg blink;
  reg prev_v_loss;
  reg prev_i_loss;
  reg prev_state;

  wire apb_setup;
  wire apb_done;
  wire [11:0] filt [0:1];
  wire [11:0] filt_v;
  wire [11:0] filt_i;
  wire sleep_done;
  wire wake_done;
  reg addr_ok;
  reg [31:0] next_rdata;

  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready;
  assign filt_v = filt[0];
  assign filt_i = filt[1];

  // one filter per analog channel, 0 = voltage, 1 = current loop
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_filt
      input_filter u_filt (
        .mclk(mclk),
        .srst(srst),
        .level(input_filter_level),
        .sample(ch == 0 ? voltage_sample : current_sample),
        .filtered(filt[ch])
      );
    end
  endgenerate

  // common 0.1 s tick for blanking, dwell and blink
  always @(posedge mclk) begin
    if (srst) begin
      tick_count <= 32'h00000000;
      tick <= 1'b0;
    end else if (tick_count >= TICK_CYCLES - 1) begin
      tick_count <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // power-up blanking; once over it never returns, even if the time is raised
  always @(posedge mclk) begin
    if (srst) begin
      blank_count <= 8'h00;
      blank_done <= 1'b0;
    end else if (!blank_done) begin
      if (blank_count >= loss_blanking_time) begin
        blank_done <= 1'b1;
      end else if (tick) begin
        blank_count <= blank_count + 8'h01;
      end
    end
  end

  // hysteresis on the filtered samples; runs even while blanked
  always @(posedge mclk) begin
    if (srst) begin
      hyst_v <= 1'b0;
      hyst_i <= 1'b0;
    end else begin
      if (filt_v < `ARS_V_LOSS_SET) begin
        hyst_v <= 1'b1;
      end else if (filt_v > `ARS_V_LOSS_CLR) begin
        hyst_v <= 1'b0;
      end
      if (filt_i < `ARS_I_LOSS_SET) begin
        hyst_i <= 1'b1;
      end else if (filt_i > `ARS_I_LOSS_CLR) begin
        hyst_i <= 1'b0;
      end
    end
  end

  // loss is reported only for inputs serving as a reference, after blanking
  always @(posedge mclk) begin
    if (srst) begin
      voltage_loss <= 1'b0;
      current_loss <= 1'b0;
      loss_action <= 4'h0;
    end else begin
      voltage_loss <= hyst_v && volt_is_ref && blank_done;
      current_loss <= hyst_i && loop_is_ref && blank_done;
      if (current_loss && current_loop_loss_response != 4'h0) begin
        loss_action <= current_loop_loss_response;
      end else if (voltage_loss) begin
        loss_action <= voltage_input_loss_response;
      end else begin
        loss_action <= 4'h0;
      end
    end
  end

  // loop scaling in tenths of a percent of the 4-20 mA span
  reg [11:0] pct_i;
  reg [11:0] pct_v;
  reg [11:0] pct_f;
  reg [11:0] span;
  reg [11:0] num;
  reg [26:0] prod;
  reg [26:0] quot;
  reg [25:0] fprod;
  reg [25:0] fquot;
  reg [26:0] iprod;
  reg [26:0] vprod;
  reg [11:0] i_off;
  always @* begin
    i_off = (filt_i > `ARS_I_ZERO) ? filt_i - `ARS_I_ZERO : 12'h000;
    iprod = i_off * `ARS_I_PCT_MUL;
    pct_i = {1'b0, iprod[26:16]};
    vprod = filt_v * `ARS_V_PCT_MUL;
    pct_v = {1'b0, vprod[26:16]};
    fprod = commanded_freq * 10'h3E8;
    fquot = (max_frequency_setting == 16'h0000) ? 26'h0000000 :
            fprod / max_frequency_setting;
    pct_f = (fquot > 26'h00003E8) ? 12'h3E8 : fquot[11:0];
    if (current_loop_high_scale >= current_loop_low_scale) begin
      span = current_loop_high_scale - current_loop_low_scale;
      num = (pct_i > current_loop_low_scale) ? pct_i - current_loop_low_scale : 12'h000;
    end else begin
      span = current_loop_low_scale - current_loop_high_scale;
      num = (pct_i < current_loop_low_scale) ? current_loop_low_scale - pct_i : 12'h000;
    end
    if (num > span) begin
      num = span;
    end
    prod = num * max_frequency_setting;
    quot = (span == 12'h000) ? 27'h0000000 : prod / span;
  end

  always @(posedge mclk) begin
    if (srst) begin
      scaled_ref <= 16'h0000;
    end else begin
      scaled_ref <= quot[15:0];
    end
  end

  // sleep/wake comparison on the selected source, sense set by level order
  reg [11:0] src_pct;
  reg inverted;
  reg below_sleep;
  reg above_wake;
  always @* begin
    case (sleep_source_select)
      `ARS_SRC_VOLT: src_pct = pct_v;
      `ARS_SRC_LOOP: src_pct = pct_i;
      `ARS_SRC_FREQ: src_pct = pct_f;
      default: src_pct = 12'h000;
    endcase
    inverted = sleep_threshold > wake_threshold;
    below_sleep = inverted ? src_pct > {2'b00, sleep_threshold} :
                  src_pct < {2'b00, sleep_threshold};
    above_wake = inverted ? src_pct < {2'b00, wake_threshold} :
                 src_pct > {2'b00, wake_threshold};
  end

  dwell_timer #(.W(13)) u_sleep_timer (
    .mclk(mclk),
    .srst(srst),
    .tick(tick),
    .cond(state == ST_AWAKE && drive_running && below_sleep &&
          sleep_source_select != `ARS_SRC_OFF),
    .limit(sleep_dwell_time),
    .done(sleep_done)
  );

  dwell_timer #(.W(13)) u_wake_timer (
    .mclk(mclk),
    .srst(srst),
    .tick(tick),
    .cond(state == ST_ASLEEP && above_wake),
    .limit(wake_dwell_time),
    .done(wake_done)
  );

  // sleep state machine; ramping itself belongs to the drive's ramp logic
  always @(posedge mclk) begin
    if (srst) begin
      state <= ST_AWAKE;
      blink <= 1'b0;
    end else begin
      case (state)
        ST_AWAKE: begin
          blink <= 1'b0;
          if (sleep_done) begin
            state <= ST_ASLEEP;
          end
        end
        ST_ASLEEP: begin
          if (tick) begin
            blink <= !blink;
          end
          if (wake_done || sleep_source_select == `ARS_SRC_OFF) begin
            state <= ST_AWAKE;
          end
        end
        default: state <= ST_AWAKE;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      sleep_active <= 1'b0;
      run_indicator_flash <= 1'b0;
      freq_target <= 16'h0000;
    end else begin
      sleep_active <= state == ST_ASLEEP;
      run_indicator_flash <= blink;
      freq_target <= (state == ST_ASLEEP) ? 16'h0000 : commanded_freq;
    end
  end

  // read mux and decode, sampled in the setup cycle
  always @* begin
    addr_ok = 1'b1;
    next_rdata = 32'h00000000;
    case (paddr)
      `ARS_OFF_LOSS_CFG: next_rdata = {22'h000000, loop_is_ref, volt_is_ref,
                                       current_loop_loss_response,
                                       voltage_input_loss_response};
      `ARS_OFF_SCALE: next_rdata = {4'h0, current_loop_high_scale, 4'h0,
                                    current_loop_low_scale};
      `ARS_OFF_FILT: next_rdata = {20'h00000, input_filter_level, loss_blanking_time};
      `ARS_OFF_SLEEP_SRC: next_rdata = {30'h00000000, sleep_source_select};
      `ARS_OFF_LEVELS: next_rdata = {6'h00, wake_threshold, 6'h00, sleep_threshold};
      `ARS_OFF_DWELL: next_rdata = {3'h0, wake_dwell_time, 3'h0, sleep_dwell_time};
      `ARS_OFF_STATUS: next_rdata = {24'h000000, loss_action, !blank_done,
                                     sleep_active, current_loss, voltage_loss};
      `ARS_OFF_IRQ_STAT: next_rdata = {28'h0000000, irq_status};
      `ARS_OFF_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
      `ARS_OFF_REF: next_rdata = {16'h0000, scaled_ref};
      default: addr_ok = 1'b0;
    endcase
  end

  // zero-wait APB: pready rises in the access cycle after every setup
  always @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      prdata <= apb_setup && !pwrite ? next_rdata : 32'h00000000;
    end
  end

  // register writes take effect at the completing edge; values are clamped
  always @(posedge mclk) begin
    if (srst) begin
      voltage_input_loss_response <= 4'h0;
      current_loop_loss_response <= 4'h0;
      volt_is_ref <= 1'b0;
      loop_is_ref <= 1'b0;
      current_loop_low_scale <= 12'h000;
      current_loop_high_scale <= `ARS_RST_HIGH_SCALE;
      loss_blanking_time <= 8'h00;
      input_filter_level <= 4'h0;
      sleep_source_select <= `ARS_SRC_OFF;
      sleep_threshold <= `ARS_RST_SLEEP_LVL;
      wake_threshold <= `ARS_RST_WAKE_LVL;
      sleep_dwell_time <= 13'h0000;
      wake_dwell_time <= 13'h0000;
      irq_mask <= 4'h0;
    end else if (apb_done && pwrite) begin
      case (paddr)
        `ARS_OFF_LOSS_CFG: begin
          voltage_input_loss_response <= (pwdata[3:0] > `ARS_MAX_RESP) ?
                                         `ARS_MAX_RESP : pwdata[3:0];
          current_loop_loss_response <= (pwdata[7:4] > `ARS_MAX_RESP) ?
                                        `ARS_MAX_RESP : pwdata[7:4];
          volt_is_ref <= pwdata[8];
          loop_is_ref <= pwdata[9];
        end
        `ARS_OFF_SCALE: begin
          current_loop_low_scale <= (pwdata[11:0] > `ARS_MAX_SCALE) ?
                                    `ARS_MAX_SCALE : pwdata[11:0];
          current_loop_high_scale <= (pwdata[27:16] > `ARS_MAX_SCALE) ?
                                     `ARS_MAX_SCALE : pwdata[27:16];
        end
        `ARS_OFF_FILT: begin
          loss_blanking_time <= (pwdata[7:0] > `ARS_MAX_BLANK) ?
                                `ARS_MAX_BLANK : pwdata[7:0];
          input_filter_level <= (pwdata[11:8] > `ARS_MAX_FILTER) ?
                                `ARS_MAX_FILTER : pwdata[11:8];
        end
        `ARS_OFF_SLEEP_SRC: sleep_source_select <= pwdata[1:0];
        `ARS_OFF_LEVELS: begin
          sleep_threshold <= (pwdata[9:0] > `ARS_MAX_LEVEL) ?
                             `ARS_MAX_LEVEL : pwdata[9:0];
          wake_threshold <= (pwdata[25:16] > `ARS_MAX_LEVEL) ?
                            `ARS_MAX_LEVEL : pwdata[25:16];
        end
        `ARS_OFF_DWELL: begin
          sleep_dwell_time <= (pwdata[12:0] > `ARS_MAX_DWELL) ?
                              `ARS_MAX_DWELL : pwdata[12:0];
          wake_dwell_time <= (pwdata[28:16] > `ARS_MAX_DWELL) ?
                             `ARS_MAX_DWELL : pwdata[28:16];
        end
        `ARS_OFF_IRQ_MASK: irq_mask <= pwdata[3:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // sticky events; a new event in the clearing read's cycle survives it
  reg [3:0] irq_set;
  always @* begin
    irq_set = 4'h0;
    irq_set[`ARS_IRQ_V_LOSS] = voltage_loss && !prev_v_loss;
    irq_set[`ARS_IRQ_I_LOSS] = current_loss && !prev_i_loss;
    irq_set[`ARS_IRQ_SLEEP] = state == ST_ASLEEP && prev_state == ST_AWAKE;
    irq_set[`ARS_IRQ_WAKE] = state == ST_AWAKE && prev_state == ST_ASLEEP;
  end

  always @(posedge mclk) begin
    if (srst) begin
      irq_status <= 4'h0;
      prev_v_loss <= 1'b0;
      prev_i_loss <= 1'b0;
      prev_state <= ST_AWAKE;
      irq <= 1'b0;
    end else begin
      prev_v_loss <= voltage_loss;
      prev_i_loss <= current_loss;
      prev_state <= state;
      if (apb_done && !pwrite && paddr == `ARS_OFF_IRQ_STAT) begin
        irq_status <= (irq_status & ~prdata[3:0]) | irq_set; // clear only what was reported
      end else begin
        irq_status <= irq_status | irq_set;
      end
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule // analog_reference_supervisor
`default_nettype wire

// *** verilog/ars_defines.vh ***
/*
  Constants for the analog reference supervisor: register offsets, field
  positions, reset values, thresholds and timing. Assumes 12-bit unsigned
  samples where full scale is 10 V on the voltage input and 20 mA on the loop.
*/
`ifndef ARS_DEFINES_VH
`define ARS_DEFINES_VH

`define ARS_CLK_MHZ 125
`define ARS_TICK_MS 100
`define ARS_TICK_CYCLES (`ARS_TICK_MS * 1000 * `ARS_CLK_MHZ)

`define ARS_OFF_LOSS_CFG 8'h00
`define ARS_OFF_SCALE 8'h04
`define ARS_OFF_FILT 8'h08
`define ARS_OFF_SLEEP_SRC 8'h0C
`define ARS_OFF_LEVELS 8'h10
`define ARS_OFF_DWELL 8'h14
`define ARS_OFF_STATUS 8'h18
`define ARS_OFF_IRQ_STAT 8'h1C
`define ARS_OFF_IRQ_MASK 8'h20
`define ARS_OFF_REF 8'h24

`define ARS_RST_HIGH_SCALE 12'h3E8
`define ARS_RST_SLEEP_LVL 10'h064
`define ARS_RST_WAKE_LVL 10'h096
`define ARS_MAX_SCALE 12'h7D0
`define ARS_MAX_LEVEL 10'h3E8
`define ARS_MAX_BLANK 8'hC8
`define ARS_MAX_DWELL 13'h1770
`define ARS_MAX_FILTER 4'hE
`define ARS_MAX_RESP 4'h8

`define ARS_V_LOSS_SET 12'h19A
`define ARS_V_LOSS_CLR 12'h266
`define ARS_I_LOSS_SET 12'h19A
`define ARS_I_LOSS_CLR 12'h266
`define ARS_I_ZERO 12'h333
`define ARS_I_PCT_MUL 15'h4E25
`define ARS_V_PCT_MUL 15'h3E84

`define ARS_SRC_OFF 2'h0
`define ARS_SRC_VOLT 2'h1
`define ARS_SRC_LOOP 2'h2
`define ARS_SRC_FREQ 2'h3

`define ARS_IRQ_V_LOSS 0
`define ARS_IRQ_I_LOSS 1
`define ARS_IRQ_SLEEP 2
`define ARS_IRQ_WAKE 3

`endif

// *** verilog/input_filter.v ***
/*
  Extra single-pole filter for one analog channel.
  Assumes one new sample per clock from logic on the same clock.
*/
`default_nettype none
module input_filter (
  input wire mclk,
  input wire srst,
  input wire [3:0] level,
  input wire [11:0] sample,
  output wire [11:0] filtered
);
  reg [25:0] acc;
  wire signed [26:0] diff;
  wire signed [26:0] delta;

  // each level step halves the gain, doubling the time constant
  assign diff = $signed({1'b0, sample, 14'h0000}) - $signed({1'b0, acc});
  assign filtered = acc[25:14];
  // shifted on its own so the sign survives; a mixed expression would shift in zeros
  assign delta = diff >>> level;

  always @(posedge mclk) begin
    if (srst) begin
      acc <= 26'h0000000;
    end else if (level == 4'h0) begin
      acc <= {sample, 14'h0000};
    end else begin
      acc <= acc + delta[25:0];
    end
  end
endmodule // input_filter
`default_nettype wire

// *** verilog/dwell_timer.v ***
/*
  Dwell timer: reports done once cond has held for limit ticks.
  Assumes tick is a one-cycle pulse on the same clock.
*/
`default_nettype none
module dwell_timer #(
  parameter W = 13
) (
  input wire mclk,
  input wire srst,
  input wire tick,
  input wire cond,
  input wire [W-1:0] limit,
  output reg done
);
  reg [W-1:0] count;

  // any drop of the condition restarts the dwell from zero
  always @(posedge mclk) begin
    if (srst || !cond) begin
      count <= {W{1'b0}};
      done <= 1'b0;
    end else if (count >= limit) begin
      done <= 1'b1;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end
endmodule // dwell_timer
`default_nettype wire

// *** testbench/analog_source.sv ***
/*
  Model of the external analog source on the terminal block.
  Assumes the bench sets targets; slow mode slews toward them like a lagging sensor.
*/
`default_nettype none
module analog_source (
  input wire logic mclk,
  input wire logic slow,
  input wire logic [11:0] volt_tgt,
  input wire logic [11:0] loop_tgt,
  output logic [11:0] voltage_sample,
  output logic [11:0] current_sample
);
  timeunit 1ns;
  timeprecision 100ps;
  // at most 256 codes a clock, so level crossings arrive late
  function automatic logic [11:0] step(input logic [11:0] now, input logic [11:0] tgt);
    if ({1'b0, tgt} > {1'b0, now} + 13'h100) begin
      return now + 12'h100;
    end
    if ({1'b0, now} > {1'b0, tgt} + 13'h100) begin
      return now - 12'h100;
    end
    return tgt;
  endfunction
  // mid-scale from time zero, so nothing looks lost before the first edge
  initial begin
    voltage_sample = 12'h800;
    current_sample = 12'h800;
  end
  always @(posedge mclk) begin
    voltage_sample <= slow ? step(voltage_sample, volt_tgt) : volt_tgt;
    current_sample <= slow ? step(current_sample, loop_tgt) : loop_tgt;
  end
endmodule // analog_source
`default_nettype wire

// *** testbench/analog_reference_supervisor_chk.sv ***
/*
  Checker for the supervisor: bus timing, loss action and sleep outputs.
  Assumes it is bound to the top module and sees its ports only.
*/
`default_nettype none
module analog_reference_supervisor_chk #(
  parameter TICK_CYCLES = 10
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [15:0] commanded_freq,
  input wire logic voltage_loss,
  input wire logic current_loss,
  input wire logic [3:0] loss_action,
  input wire logic [15:0] freq_target,
  input wire logic sleep_active,
  input wire logic run_indicator_flash
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_flash;
  logic [31:0] gap;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  // cycles since the flash last changed while asleep; a stuck flash grows it
  always @(posedge mclk) begin
    last_flash <= run_indicator_flash;
    if (srst || !sleep_active || run_indicator_flash != last_flash) begin
      gap <= 32'h0;
    end else begin
      gap <= gap + 32'h1;
    end
  end
  AST_READY_AFTER_SETUP: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE_CYCLE: assert property (pready |-> s_access ##1 !pready)
    else $error("ready outside a single access cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_RDATA_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_ACTION_RANGE: assert property (loss_action <= 4'h8)
    else $error("loss action code out of range");
  AST_ACTION_NEEDS_LOSS: assert property (loss_action != 4'h0 |-> $past(voltage_loss) || $past(current_loss))
    else $error("loss action without a loss");
  AST_ASLEEP_ZERO_FREQ: assert property (sleep_active && $past(sleep_active) |-> freq_target == 16'h0)
    else $error("frequency target not zero while asleep");
  AST_AWAKE_PASSES_FREQ: assert property (!sleep_active && !$past(sleep_active) && !$past(srst) |-> freq_target == $past(commanded_freq))
    else $error("frequency target not following command");
  AST_FLASH_OFF_AWAKE: assert property (!sleep_active && !$past(sleep_active) |-> !run_indicator_flash)
    else $error("run indicator flashing while awake");
  AST_FLASH_PERIOD: assert property (gap <= TICK_CYCLES + 2)
    else $error("run indicator not toggling each tick");
endmodule // analog_reference_supervisor_chk
bind analog_reference_supervisor analog_reference_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk, .srst, .psel, .penable, .pready, .pslverr, .prdata, .commanded_freq, .voltage_loss,
  .current_loss, .loss_action, .freq_target, .sleep_active, .run_indicator_flash
);
`default_nettype wire

// *** testbench/analog_reference_supervisor_test.sv ***
/*
  Testbench for the supervisor: registers, loss, scaling and sleep over APB.
  Assumes the source model and the bound checker are compiled with it.
*/
`default_nettype none
module analog_reference_supervisor_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, drive_running = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, voltage_loss, current_loss, sleep_active, run_indicator_flash, irq;
  logic [11:0] voltage_sample, current_sample, volt_tgt = 12'h800, loop_tgt = 12'h800;
  logic [15:0] commanded_freq = 16'h0800, max_frequency_setting = 16'h1000;
  logic [15:0] scaled_ref, freq_target;
  logic [3:0] loss_action;
  int err_count = 0, checks_done = 0, s, i;

  always #4 mclk = ~mclk;

  analog_source src (.mclk, .slow, .volt_tgt, .loop_tgt, .voltage_sample, .current_sample);
  // short tick keeps dwell times to tens of cycles
  analog_reference_supervisor #(.TICK_CYCLES(10)) DUT (.mclk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .voltage_sample, .current_sample,
    .drive_running, .commanded_freq, .max_frequency_setting, .voltage_loss, .current_loss,
    .loss_action, .scaled_ref, .freq_target, .sleep_active, .run_indicator_flash, .irq);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one transfer; the idle edge after it keeps strobes from being set twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    if (n == 50) begin
      err_count++;
      $display("unexpected at %0t: no ready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic drv(input logic [11:0] v, input logic [11:0] c, input int n);
    volt_tgt <= v;
    loop_tgt <= c;
    tk(n);
  endtask
  task automatic ended(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // the tests need under a thousand cycles; this allows 50000, over fifty times that
  initial begin
    #400000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end

  initial begin
    tk(4);
    srst <= 1'b0;
    tk(1);
    rd(8'h04, 32'h03E80000);
    rd(8'h10, 32'h00960064);
    rd(8'h18, 32'h00000000);
    apb(1'b0, 8'h28, 32'h0);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h07D007D0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h03E803E8);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h17701770);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h00000EC8);
    ended("registers");
    // heaviest filter holds the old level, so a drop to zero is not yet seen
    drv(12'h000, 12'h000, 12);
    wr(8'h00, 32'h00000200);
    tk(12);
    chk(32'(current_loss), 32'h0);
    wr(8'h08, 32'h0);
    tk(8);
    chk(32'(current_loss), 32'h1);
    chk(32'(voltage_loss), 32'h0);
    chk(32'(irq), 32'h0);
    for (i = 1; i < 9; i++) begin
      wr(8'h00, 32'h200 | (i << 4));
      tk(3);
      chk(32'(loss_action), i);
    end
    drv(12'h000, 12'h266, 8);
    chk(32'(current_loss), 32'h1);
    drv(12'h000, 12'h267, 8);
    chk(32'(current_loss), 32'h0);
    drv(12'h000, 12'h19A, 8);
    chk(32'(current_loss), 32'h0);
    rd(8'h1C, 32'h00000002);
    wr(8'h20, 32'h00000002);
    drv(12'h000, 12'h199, 8);
    chk(32'(irq), 32'h1);
    rd(8'h1C, 32'h00000002);
    tk(3);
    chk(32'(irq), 32'h0);
    drv(12'h000, 12'h800, 8);
    wr(8'h00, 32'h00000103);
    tk(8);
    chk(32'(voltage_loss), 32'h1);
    chk(32'(loss_action), 32'h3);
    drv(12'h266, 12'h800, 8);
    chk(32'(voltage_loss), 32'h1);
    drv(12'h267, 12'h800, 8);
    chk(32'(voltage_loss), 32'h0);
    rd(8'h1C, 32'h00000001);
    ended("loss");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h03E80000);
    drv(12'h800, 12'hFFF, 8);
    chk(32'(scaled_ref >= 16'hE00), 32'h1);
    drv(12'h800, 12'h333, 8);
    chk(32'(scaled_ref < 16'h100), 32'h1);
    wr(8'h04, 32'h000003E8);
    tk(4);
    chk(32'(scaled_ref >= 16'hE00), 32'h1);
    wr(8'h04, 32'h01F401F4);
    tk(4);
    chk(32'(scaled_ref), 32'h0);
    wr(8'h04, 32'h07D00000);
    drv(12'h800, 12'h999, 8);
    chk(32'(scaled_ref > 16'h380 && scaled_ref < 16'h480), 32'h1);
    ended("scaling");
    wr(8'h10, 32'h00960064);
    wr(8'h14, 32'h00010004);
    drive_running <= 1'b1;
    slow <= 1'b1;
    for (s = 1; s < 4; s++) begin
      wr(8'h0C, 32'(s));
      commanded_freq <= 16'h1000;
      drv(12'hFFF, 12'hFFF, 30);
      commanded_freq <= (s == 3) ? 16'h0 : 16'h1000;
      drv(12'h000, 12'h333, 25);
      chk(32'(sleep_active), 32'h0);
      tk(40);
      chk(32'(sleep_active), 32'h1);
      chk(32'(freq_target), 32'h0);
      r[0] = run_indicator_flash;
      tk(10);
      chk(32'(run_indicator_flash), 32'(!r[0]));
      commanded_freq <= 16'h1000;
      drv(12'hFFF, 12'hFFF, 30);
      chk(32'(sleep_active), 32'h0);
      chk(32'(freq_target), 32'h1000);
    end
    rd(8'h1C, 32'h0000000C);
    wr(8'h0C, 32'h0);
    drv(12'h000, 12'h333, 60);
    chk(32'(sleep_active), 32'h0);
    wr(8'h0C, 32'h1);
    drive_running <= 1'b0;
    tk(60);
    chk(32'(sleep_active), 32'h0);
    drive_running <= 1'b1;
    wr(8'h10, 32'h00640096);
    drv(12'hFFF, 12'h333, 70);
    chk(32'(sleep_active), 32'h1);
    drv(12'h000, 12'h333, 40);
    chk(32'(sleep_active), 32'h0);
    ended("sleep");
    test_done;
  end
endmodule // analog_reference_supervisor_test
`default_nettype wire
